// ### hdl/adc_ctrl.sv
// Converter control: registers, start sequence, divider, sequencing, result formatting and routing
// Operation
// - Every result is a 12-bit unsigned value, external or internal source.
// - Conversion begins only after start bit written high then low.
// - Read-only busy flag bit 6 set on start, cleared on completion.
// - Enable bit 5 powers converter; when off, result registers hold.
// - Format bit picks left or right justification across two bytes.
// - Result bits carrying no data read as zero.
// - Channel codes map to pins 0,1,3-8; codes 12-15 leave input floating.
// - Source field routes external, supply fractions, amplifier fractions or ground.
// - Internal source selected disconnects the external channel path.
// - Clock select 0-7 divides system clock by 1 to 128.
// - Control 1 bit 3 ignores writes, reads zero.
// - Pin in converter use drops shared function and pull-high.
// - Bandgap enable bit 0 switches bandgap reference on or off.
// - Reference select: 00 supply, 01 external pin, 1x amplifier output.
module adc_ctrl
  import adc_pkg::*;
#(
  parameter int NUM_PINS = 9,
  parameter int DIV_W = 7
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Analog core
  input wire logic [11:0] core_result,
  output logic core_power,
  output logic core_sample,
  output logic core_step,
  // Routing
  output logic [NUM_PINS-1:0] ext_analog_channel,
  output logic [1:0] internal_src,
  output logic [1:0] internal_scale,
  output logic [1:0] reference_sel,
  output logic bandgap_enable,
  output logic amplifier_enable,
  output logic amplifier_input_sel,
  output logic [1:0] amplifier_gain_sel,
  // Pin sharing
  input wire logic [NUM_PINS-1:0] pin_adc_func,
  output logic [NUM_PINS-1:0] pin_gpio_off,
  output logic [NUM_PINS-1:0] pin_pullup_off,
  // Interrupt
  output logic irq
);
  import adc_pkg::*;

  typedef enum logic [1:0] {ADC_IDLE, ADC_CONV, ADC_DONE} adc_state_t;

  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] bgr;
    logic [7:0] res_lo;
    logic [7:0] res_hi;
    logic irq_stat;
    logic irq_mask;
    logic start_armed;
    adc_state_t state;
    logic [DIV_W-1:0] div_cnt;
    logic [4:0] tick_cnt;
    logic [7:0] rdata;
    logic irq;
    logic sample;
    logic step;
    logic [NUM_PINS-1:0] chan;
    logic [1:0] isrc;
    logic [1:0] iscale;
    logic [NUM_PINS-1:0] pin_off;
  } adc_st_t;

  adc_st_t st_q, st_d;

  // Divider terminal count for code 0..7
  function automatic logic [DIV_W-1:0] div_last(input logic [2:0] code);
    div_last = DIV_W'((1 << code) - 1);
  endfunction

  // Pin code to one-hot, floating and reserved codes connect nothing
  function automatic logic [NUM_PINS-1:0] chan_decode(input logic [3:0] code);
    chan_decode = '0;
    if (code != 4'h2 && code < ADC_CH_FLOAT_MIN && int'(code) < NUM_PINS) begin
      chan_decode[code] = 1'b1;
    end
  endfunction

  logic conv_tick;
  logic [11:0] res;
  logic [3:0] src;
  logic ext_sel;

  assign res = core_result;
  assign src = st_q.ctl1[7:4];
  // Conversion-clock tick from the divider
  assign conv_tick = (st_q.div_cnt == div_last(st_q.ctl1[2:0]));

  always_comb begin
    st_d = st_q;
    st_d.sample = 1'b0;
    st_d.step = 1'b0;
    // Divider free-runs while enabled
    if (!st_q.ctl0[ADC_C0_EN] || conv_tick) begin
      st_d.div_cnt = '0;
    end else begin
      st_d.div_cnt = st_q.div_cnt + DIV_W'(1);
    end

    // Register writes
    if (reg_wr) begin
      if (reg_addr == ADC_OFF_CTL0) begin
        st_d.ctl0 = (reg_wdata & ADC_C0_WMASK) | (st_q.ctl0 & ~ADC_C0_WMASK);
        // Start edge armed on high, fires on following low
        if (reg_wdata[ADC_C0_START]) begin
          st_d.start_armed = 1'b1;
        end else if (st_q.start_armed) begin
          st_d.start_armed = 1'b0;
          if (st_q.ctl0[ADC_C0_EN] && st_q.state == ADC_IDLE) begin
            st_d.state = ADC_CONV;
            st_d.ctl0[ADC_C0_BUSY] = 1'b1;
            st_d.tick_cnt = '0;
            st_d.sample = 1'b1;
            st_d.div_cnt = '0;
          end
        end
      end else if (reg_addr == ADC_OFF_CTL1) begin
        st_d.ctl1 = reg_wdata & ADC_C1_WMASK;
      end else if (reg_addr == ADC_OFF_CTL2) begin
        st_d.ctl2 = reg_wdata & ADC_C2_WMASK;
      end else if (reg_addr == ADC_OFF_BGR) begin
        st_d.bgr = reg_wdata & ADC_BGR_WMASK;
      end else if (reg_addr == ADC_OFF_IRQ_MASK) begin
        st_d.irq_mask = reg_wdata[0];
      end
    end

    // Read clears interrupt status
    if (reg_rd && reg_addr == ADC_OFF_IRQ_STAT) begin
      st_d.irq_stat = 1'b0;
    end

    // Sequencer
    case (st_q.state)
      ADC_IDLE: begin
      end
      ADC_CONV: begin
        if (!st_q.ctl0[ADC_C0_EN]) begin
          // Disabled mid-conversion: abort, results untouched
          st_d.state = ADC_IDLE;
          st_d.ctl0[ADC_C0_BUSY] = 1'b0;
        end else if (conv_tick) begin
          st_d.step = 1'b1;
          st_d.tick_cnt = st_q.tick_cnt + 5'h1;
          if (st_q.tick_cnt == ADC_CONV_TICKS - 5'h1) begin
            st_d.state = ADC_DONE;
          end
        end
      end
      ADC_DONE: begin
        // Result stored this cycle, busy drops with it
        // Disable on the last tick drops both the result and the event
        if (st_q.ctl0[ADC_C0_EN] && st_q.ctl0[ADC_C0_FMT]) begin
          st_d.res_hi = {4'h0, res[11:8]};
          st_d.res_lo = res[7:0];
        end else if (st_q.ctl0[ADC_C0_EN]) begin
          st_d.res_hi = res[11:4];
          st_d.res_lo = {res[3:0], 4'h0};
        end
        st_d.ctl0[ADC_C0_BUSY] = 1'b0;
        // Set wins over a same-cycle status read
        st_d.irq_stat = st_d.irq_stat | st_q.ctl0[ADC_C0_EN];
        st_d.state = ADC_IDLE;
      end
      default: st_d.state = ADC_IDLE;
    endcase

    // Routing
    ext_sel = (src == 4'h0) || (src == 4'h4) || (src[3:2] == 2'h3);
    st_d.chan = ext_sel ? chan_decode(st_q.ctl0[3:0]) : '0;
    if (ext_sel) begin
      st_d.isrc = ADC_SRC_EXT;
      st_d.iscale = 2'h0;
    end else if (src[3]) begin
      st_d.isrc = ADC_SRC_GND;
      st_d.iscale = 2'h0;
    end else begin
      st_d.isrc = src[2] ? ADC_SRC_AMP : ADC_SRC_SUPPLY;
      st_d.iscale = src[1:0] - 2'h1;
    end
    st_d.pin_off = pin_adc_func;

    // Read data, one cycle later
    st_d.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == ADC_OFF_RES_LO) begin
        st_d.rdata = st_q.res_lo;
      end else if (reg_addr == ADC_OFF_RES_HI) begin
        st_d.rdata = st_q.res_hi;
      end else if (reg_addr == ADC_OFF_CTL0) begin
        st_d.rdata = st_q.ctl0;
      end else if (reg_addr == ADC_OFF_CTL1) begin
        st_d.rdata = st_q.ctl1;
      end else if (reg_addr == ADC_OFF_CTL2) begin
        st_d.rdata = st_q.ctl2;
      end else if (reg_addr == ADC_OFF_BGR) begin
        st_d.rdata = st_q.bgr;
      end else if (reg_addr == ADC_OFF_IRQ_STAT) begin
        st_d.rdata = {7'h00, st_q.irq_stat};
      end else if (reg_addr == ADC_OFF_IRQ_MASK) begin
        st_d.rdata = {7'h00, st_q.irq_mask};
      end
    end
    st_d.irq = st_d.irq_stat & st_d.irq_mask;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.ctl0 <= ADC_C0_RST;
      st_q.ctl1 <= ADC_C1_RST;
      st_q.ctl2 <= ADC_C2_RST;
      st_q.bgr <= ADC_BGR_RST;
      st_q.state <= ADC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign irq = st_q.irq;
  assign core_power = st_q.ctl0[ADC_C0_EN];
  assign core_sample = st_q.sample;
  assign core_step = st_q.step;
  assign ext_analog_channel = st_q.chan;
  assign internal_src = st_q.isrc;
  assign internal_scale = st_q.iscale;
  assign reference_sel = st_q.ctl2[3:2];
  assign bandgap_enable = st_q.bgr[0];
  assign amplifier_enable = st_q.ctl2[7];
  assign amplifier_input_sel = st_q.ctl2[4];
  assign amplifier_gain_sel = st_q.ctl2[1:0];
  assign pin_gpio_off = st_q.pin_off;
  assign pin_pullup_off = st_q.pin_off;

  property p_start_seq;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(st_q.ctl0[ADC_C0_BUSY])
        |-> $past(st_q.start_armed) && !st_q.start_armed && st_q.sample;
  endproperty
  a_start_seq: assert property (p_start_seq) else $error("busy rose without armed start");

  property p_busy_done;
    @(posedge sys_clk) disable iff (!rst_n)
      $fell(st_q.ctl0[ADC_C0_BUSY]) && st_q.ctl0[ADC_C0_EN] |-> st_q.irq_stat;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("busy cleared without result");

  property p_hold_off;
    @(posedge sys_clk) disable iff (!rst_n)
      !st_q.ctl0[ADC_C0_EN] |=> $stable(st_q.res_hi) && $stable(st_q.res_lo);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("result changed while disabled");

  property p_fmt_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      $changed(st_q.res_lo) |-> (st_q.res_lo[3:0] == 4'h0) || (st_q.res_hi[7:4] == 4'h0);
  endproperty
  a_fmt_zero: assert property (p_fmt_zero) else $error("unused result bits set");

  property p_fmt_right;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q.state == ADC_DONE && st_q.ctl0[ADC_C0_EN] && st_q.ctl0[ADC_C0_FMT]
        |=> st_q.res_lo == $past(core_result[7:0]) && st_q.res_hi[3:0] == $past(core_result[11:8]);
  endproperty
  a_fmt_right: assert property (p_fmt_right) else $error("right justify wrong");

  property p_int_disc;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q.isrc != ADC_SRC_EXT |-> st_q.chan == '0;
  endproperty
  a_int_disc: assert property (p_int_disc) else $error("external path left on");

  property p_bit3;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q.ctl1[3] == 1'b0;
  endproperty
  a_bit3: assert property (p_bit3) else $error("control 1 bit 3 set");

  property p_step_div;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q.step |-> $past(st_q.div_cnt) == div_last($past(st_q.ctl1[2:0]));
  endproperty
  a_step_div: assert property (p_step_div) else $error("step off divided clock");

  property p_fmt_left;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q.state == ADC_DONE && st_q.ctl0[ADC_C0_EN] && !st_q.ctl0[ADC_C0_FMT]
        |=> st_q.res_hi == $past(core_result[11:4])
          && st_q.res_lo == {$past(core_result[3:0]), 4'h0};
  endproperty
  a_fmt_left: assert property (p_fmt_left) else $error("left justify wrong");

  property p_abort;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q.state == ADC_CONV && !st_q.ctl0[ADC_C0_EN]
        |=> st_q.state == ADC_IDLE && !st_q.ctl0[ADC_C0_BUSY] && !$rose(st_q.irq_stat);
  endproperty
  a_abort: assert property (p_abort) else $error("disable did not abort");

  property p_done_store;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q.state == ADC_DONE && st_q.ctl0[ADC_C0_EN]
        |=> st_q.irq_stat && !st_q.ctl0[ADC_C0_BUSY] && st_q.state == ADC_IDLE;
  endproperty
  a_done_store: assert property (p_done_store) else $error("completion not stored");

  property p_busy_state;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q.ctl0[ADC_C0_BUSY] == (st_q.state != ADC_IDLE);
  endproperty
  a_busy_state: assert property (p_busy_state) else $error("busy flag out of step");

  property p_irq_level;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q.irq == (st_q.irq_stat & st_q.irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_gnd_route;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(st_q.ctl1[7:6]) == 2'h2 |-> st_q.isrc == ADC_SRC_GND && st_q.chan == '0;
  endproperty
  a_gnd_route: assert property (p_gnd_route) else $error("ground route wrong");

  property p_supply_route;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(st_q.ctl1[7:6]) == 2'h0 && $past(st_q.ctl1[5:4]) != 2'h0
        |-> st_q.isrc == ADC_SRC_SUPPLY && st_q.chan == '0;
  endproperty
  a_supply_route: assert property (p_supply_route) else $error("supply route wrong");

  property p_float;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(st_q.ctl0[3:2]) == 2'h3 |-> st_q.chan == '0;
  endproperty
  a_float: assert property (p_float) else $error("floating code connected a pin");

  property p_pin_off;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n) |-> st_q.pin_off == $past(pin_adc_func);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin release lags");

  property p_rd_once;
    @(posedge sys_clk) disable iff (!rst_n)
      !$past(reg_rd) |-> st_q.rdata == 8'h00;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read data outside its cycle");

  property p_sample_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q.sample |-> $rose(st_q.ctl0[ADC_C0_BUSY]) && st_q.state == ADC_CONV;
  endproperty
  a_sample_pulse: assert property (p_sample_pulse) else $error("sample without start");

  property p_done_tick;
    @(posedge sys_clk) disable iff (!rst_n)
      st_q.state == ADC_DONE |-> st_q.step && $past(st_q.tick_cnt) == ADC_CONV_TICKS - 5'h1;
  endproperty
  a_done_tick: assert property (p_done_tick) else $error("done off the last tick");
endmodule // adc_ctrl

// ### hdl/adc_pkg.sv
// Package: register map, field positions, reset values and timing counts of the converter control
package adc_pkg;
  // Register offsets (8-bit register port)
  localparam logic [3:0] ADC_OFF_RES_LO = 4'h0;
  localparam logic [3:0] ADC_OFF_RES_HI = 4'h1;
  localparam logic [3:0] ADC_OFF_CTL0 = 4'h2;
  localparam logic [3:0] ADC_OFF_CTL1 = 4'h3;
  localparam logic [3:0] ADC_OFF_CTL2 = 4'h4;
  localparam logic [3:0] ADC_OFF_BGR = 4'h5;
  localparam logic [3:0] ADC_OFF_IRQ_STAT = 4'h6;
  localparam logic [3:0] ADC_OFF_IRQ_MASK = 4'h7;
  // Control 0 fields
  localparam int ADC_C0_START = 7;
  localparam int ADC_C0_BUSY = 6;
  localparam int ADC_C0_EN = 5;
  localparam int ADC_C0_FMT = 4;
  // Writable bit masks
  localparam logic [7:0] ADC_C0_WMASK = 8'hbf;
  localparam logic [7:0] ADC_C1_WMASK = 8'hf7;
  localparam logic [7:0] ADC_C2_WMASK = 8'h9f;
  localparam logic [7:0] ADC_BGR_WMASK = 8'h01;
  localparam logic [7:0] ADC_IRQ_WMASK = 8'h01;
  // Reset values
  localparam logic [7:0] ADC_C0_RST = 8'h00;
  localparam logic [7:0] ADC_C1_RST = 8'h00;
  localparam logic [7:0] ADC_C2_RST = 8'h00;
  localparam logic [7:0] ADC_BGR_RST = 8'h00;
  // Conversion length in conversion-clock ticks (16 steps after the sample)
  localparam logic [4:0] ADC_CONV_TICKS = 5'h10;
  // Channel and source codes
  localparam logic [3:0] ADC_CH_FLOAT_MIN = 4'hc;
  localparam logic [1:0] ADC_SRC_SUPPLY = 2'h0;
  localparam logic [1:0] ADC_SRC_AMP = 2'h1;
  localparam logic [1:0] ADC_SRC_GND = 2'h2;
  localparam logic [1:0] ADC_SRC_EXT = 2'h3;
endpackage

// ### sim/adc_core_model.sv
// Analog core stand-in: one chosen code per conversion, tick counting
module adc_core_model (
  // Clock
  input wire logic sys_clk,
  // Core side
  input wire logic core_power,
  input wire logic core_sample,
  input wire logic core_step,
  // Bench side
  input wire logic [11:0] next_code,
  output logic [11:0] core_result,
  output int steps,
  output int gap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] held = 12'h000;
  int since = 0;
  // Unpowered core output wanders so a stale capture shows
  assign core_result = core_power ? held : held ^ {12{since[0]}};
  always @(posedge sys_clk) begin
    since <= since + 1;
    if (core_sample) begin
      held <= next_code;
      steps <= 0;
      since <= 0;
    end else if (core_step) begin
      steps <= steps + 1;
      gap <= since + 1;
      since <= 0;
    end
  end
endmodule // adc_core_model

// ### sim/test_adc_ctrl.sv
// Register-level bench for the converter control block
module test_adc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_pkg::*;
  logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, core_power, core_sample, core_step, irq;
  logic bandgap_enable, amplifier_enable, amplifier_input_sel;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_q, eh, el;
  logic [11:0] core_result, next_code = 12'h000;
  logic [8:0] ext_analog_channel, pin_adc_func = 9'h000, pin_gpio_off, pin_pullup_off;
  logic [1:0] internal_src, internal_scale, reference_sel, amplifier_gain_sel, es;
  int failures = 0, tests_run = 0, cycles = 0, steps, gap;
  always #4 sys_clk = ~sys_clk;

  adc_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_result(core_result),
    .core_power(core_power), .core_sample(core_sample), .core_step(core_step),
    .ext_analog_channel(ext_analog_channel), .internal_src(internal_src),
    .internal_scale(internal_scale), .reference_sel(reference_sel),
    .bandgap_enable(bandgap_enable), .amplifier_enable(amplifier_enable),
    .amplifier_input_sel(amplifier_input_sel), .amplifier_gain_sel(amplifier_gain_sel),
    .pin_adc_func(pin_adc_func), .pin_gpio_off(pin_gpio_off),
    .pin_pullup_off(pin_pullup_off), .irq(irq));
  adc_core_model core (.sys_clk(sys_clk), .core_power(core_power), .core_sample(core_sample),
    .core_step(core_step), .next_code(next_code), .core_result(core_result), .steps(steps),
    .gap(gap));

  task automatic conclude();
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    rd(a, rd_q);
    chk({4'h0, rd_q}, {4'h0, exp});
  endtask
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic convert(input logic [7:0] c0, input int k);
    int n;
    wr(ADC_OFF_CTL0, c0 | 8'h80);
    wr(ADC_OFF_CTL0, c0);
    rd(ADC_OFF_CTL0, rd_q);
    chk({11'h0, rd_q[ADC_C0_BUSY]}, 12'h001);
    n = 0;
    while (rd_q[ADC_C0_BUSY] !== 1'b0 && n < 3000) begin
      rd(ADC_OFF_CTL0, rd_q);
      n++;
    end
    chk({4'h0, rd_q}, {4'h0, c0});
    chk(12'(steps), 12'h010);
    chk(12'(gap), 12'(1 << k));
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 2; a < 16; a++) rchk(4'(a), 8'h00);
    wr(ADC_OFF_CTL1, 8'hff);
    rchk(ADC_OFF_CTL1, 8'hf7);
    wr(ADC_OFF_CTL2, 8'hff);
    rchk(ADC_OFF_CTL2, 8'h9f);
    wr(ADC_OFF_BGR, 8'hff);
    rchk(ADC_OFF_BGR, 8'h01);
    chk({7'h0, bandgap_enable, amplifier_enable, amplifier_input_sel, amplifier_gain_sel},
      12'h01f);
    wr(4'h8, 8'hff);
    rchk(4'h8, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wr(ADC_OFF_CTL2, 8'(r << 2));
      settle();
      chk({10'h0, reference_sel}, 12'(r));
    end
    for (int c = 0; c < 16; c++) begin
      if (c == 2 || (c > 8 && c < 12)) continue;
      wr(ADC_OFF_CTL0, 8'h20 | 8'(c));
      settle();
      chk({3'h0, ext_analog_channel}, (c < 9) ? 12'(1 << c) : 12'h000);
    end
    wr(ADC_OFF_CTL0, 8'h21);
    for (int s = 0; s < 16; s++) begin
      wr(ADC_OFF_CTL1, 8'(s << 4));
      settle();
      es = (s inside {0, 4, [12:15]}) ? ADC_SRC_EXT : (s < 4) ? ADC_SRC_SUPPLY :
        (s < 8) ? ADC_SRC_AMP : ADC_SRC_GND;
      chk({3'h0, ext_analog_channel}, (es == ADC_SRC_EXT) ? 12'h002 : 12'h000);
      chk({10'h0, internal_src}, {10'h0, es});
      if (s % 4 != 0 && s < 8) chk({10'h0, internal_scale}, 12'(s % 4 - 1));
    end
    @(posedge sys_clk);
    pin_adc_func <= 9'h1a5;
    settle();
    chk({3'h0, pin_gpio_off}, 12'h1a5);
    chk({3'h0, pin_pullup_off}, 12'h1a5);
    wr(ADC_OFF_IRQ_MASK, 8'h01);
    for (int k = 0; k < 8; k++) begin
      if (k == 7) wr(ADC_OFF_IRQ_MASK, 8'h00);
      wr(ADC_OFF_CTL1, 8'(k));
      next_code <= 12'h9c3 ^ 12'(k * 291);
      convert(8'h21 | 8'(k % 2 << 4), k);
      chk({11'h0, irq}, 12'(k != 7));
      rchk(ADC_OFF_IRQ_STAT, 8'h01);
      eh = (k % 2 == 1) ? {4'h0, next_code[11:8]} : next_code[11:4];
      el = (k % 2 == 1) ? next_code[7:0] : {next_code[3:0], 4'h0};
      rchk(ADC_OFF_RES_HI, eh);
      rchk(ADC_OFF_RES_LO, el);
      chk({11'h0, irq}, 12'h000);
    end
    // Disable mid-conversion: busy drops, results and events untouched
    wr(ADC_OFF_CTL0, 8'ha1);
    next_code <= 12'h5a5;
    rchk(ADC_OFF_CTL0, 8'ha1);
    wr(ADC_OFF_CTL0, 8'h21);
    rchk(ADC_OFF_CTL0, 8'h61);
    wr(ADC_OFF_CTL0, 8'h01);
    rchk(ADC_OFF_CTL0, 8'h01);
    rchk(ADC_OFF_IRQ_STAT, 8'h00);
    rchk(ADC_OFF_RES_HI, eh);
    rchk(ADC_OFF_RES_LO, el);
    // Disabled core: the start pair is dropped and results hold
    wr(ADC_OFF_CTL0, 8'h80);
    wr(ADC_OFF_CTL0, 8'h00);
    next_code <= 12'h000;
    rchk(ADC_OFF_CTL0, 8'h00);
    chk({11'h0, core_power}, 12'h000);
    wr(ADC_OFF_CTL0, 8'h20);
    rchk(ADC_OFF_CTL0, 8'h20);
    rchk(ADC_OFF_RES_HI, eh);
    rchk(ADC_OFF_RES_LO, el);
    conclude();
  end
endmodule // test_adc_ctrl
